// file: rxie_regs.svh
// Register offsets, reset values and field layout of the receive-path interrupt enable block
`ifndef RXIE_REGS_SVH
`define RXIE_REGS_SVH

`define RXIE_OFS_FLAGS    32'h0000_0348
`define RXIE_OFS_ENABLE   32'h0000_034c
`define RXIE_OFS_SUMMARY  32'h0000_03f0

`define RXIE_RST_FLAGS    32'h0000_0000
`define RXIE_RST_ENABLE   32'h0000_0000
`define RXIE_RST_RDATA    32'h0000_0000
`define RXIE_RST_ADDR     32'h0000_0000

`define RXIE_MASK_BUF     32'hffff_0000
`define RXIE_MASK_GEN     32'h0000_ff7f
`define RXIE_MASK_FLAGS   32'hffff_ff7f
`define RXIE_SUM_PAD      30'h0000_0000

`define RXIE_RESP_OKAY    2'h0
`define RXIE_RESP_SLVERR  2'h2

`endif

// file: rxie_pkg.sv
// Types shared by the receive-path interrupt enable block
package rxie_pkg;

  // Bit order matches the flag and enable registers, bit 31 first
  typedef struct packed {
    logic [7:0] buffer_packet_abort;
    logic [7:0] buffer_packet_confirmed;
    logic       parity_toggle_stream_b;
    logic       parity_toggle_stream_a;
    logic       crypt_mode_mismatch_b;
    logic       crypt_mode_mismatch_a;
    logic       video_header_split_fault_b;
    logic       video_header_split_fault_a;
    logic       video_order_fault_b;
    logic       video_order_fault_a;
    logic       rsvd7;
    logic       busy_ack_sent;
    logic       payload_check_fail;
    logic       no_buffer_target;
    logic       illegal_tcode_abort;
    logic       rx_not_idle_busied;
    logic       reset_start_write_seen;
    logic       self_id_phase_done;
  } rxie_events_t;

  typedef struct packed {
    logic rx_buffer_summary;
    logic rx_general_summary;
  } rxie_summary_t;

  typedef struct packed {
    rxie_summary_t summary;
  } rxie_gate_st_t;

  typedef struct packed {
    logic         awready;
    logic         aw_held;
    logic [31:0]  aw_addr;
    logic         wready;
    logic         w_held;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         arready;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    rxie_events_t enable;
    rxie_events_t flags;
  } rxie_top_st_t;

endpackage : rxie_pkg

// file: rxie_gate.sv
// Enable gating of event flags onto the two receive-path summary bits
`timescale 1ns/1ps
`include "rxie_regs.svh"

module rxie_gate
  import rxie_pkg::*;
(
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Flags and enables
  input  wire rxie_events_t  flags,
  input  wire rxie_events_t  enable,
  // Summary bits
  output      rxie_summary_t summary
);

  rxie_gate_st_t st_r;
  rxie_gate_st_t st_nxt;
  logic [31:0]   hit;

  // Reserved bit 7 is masked out below, so it never gates anything
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_hit
      assign hit[i] = flags[i] & enable[i];
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    st_nxt.summary.rx_buffer_summary  = |(hit & `RXIE_MASK_BUF);
    st_nxt.summary.rx_general_summary = |(hit & `RXIE_MASK_GEN);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign summary = st_r.summary;

endmodule : rxie_gate

// file: rxie_top.sv
// Receive-path interrupt enable block with AXI4-Lite register slave
//
// Functional notes
// - Buffer abort enables 31:24 drive buffer summary
// - Buffer confirm enables 23:16 drive buffer summary
// - Enables 15,14 gate parity-toggle flags B,A
// - Enables 13,12 gate crypt-mode mismatch B,A
// - Enables 11,10 gate video split faults B,A
// - Enables 9,8 gate video order faults B,A
// - Enable 6 gates busy-ack-sent flag
// - Enable 5 gates payload check failure flag
// - Enable 4 gates no-buffer-target abort flag
// - Enable 3 gates illegal tcode abort flag
// - Enable 2 gates not-idle busied flag
// - Enable 1 gates reset-start write flag
// - Enable 0 gates self-ID done flag
// - Cleared enable blocks summary; flag still records
// - Packet abort raises that buffer's abort flag
`timescale 1ns/1ps
`include "rxie_regs.svh"

module rxie_top
  import rxie_pkg::*;
(
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite write address
  input  wire logic [31:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output      logic          s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output      logic          s_axi_wready,
  // AXI4-Lite write response
  output      logic [1:0]    s_axi_bresp,
  output      logic          s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output      logic          s_axi_arready,
  // AXI4-Lite read data
  output      logic [31:0]   s_axi_rdata,
  output      logic [1:0]    s_axi_rresp,
  output      logic          s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // One-cycle event pulses from the receive path
  input  wire rxie_events_t  rx_events,
  // Flags and summary toward the system interrupt register
  output      rxie_events_t  rx_path_event_flags,
  output      rxie_summary_t system_irq_summary
);

  localparam rxie_top_st_t RST_ST = '{
    awready : 1'h1,
    aw_held : 1'h0,
    aw_addr : `RXIE_RST_ADDR,
    wready  : 1'h1,
    w_held  : 1'h0,
    wdata   : `RXIE_RST_RDATA,
    wstrb   : 4'h0,
    bvalid  : 1'h0,
    bresp   : `RXIE_RESP_OKAY,
    arready : 1'h1,
    rvalid  : 1'h0,
    rdata   : `RXIE_RST_RDATA,
    rresp   : `RXIE_RESP_OKAY,
    enable  : `RXIE_RST_ENABLE,
    flags   : `RXIE_RST_FLAGS
  };

  rxie_top_st_t  st_r;
  rxie_top_st_t  st_nxt;
  rxie_summary_t summary;
  logic [31:0]   byte_mask;
  logic [31:0]   set_vec;
  logic [31:0]   clr_vec;
  logic [31:0]   flag_vec;

  assign byte_mask = {{8{st_r.wstrb[3]}}, {8{st_r.wstrb[2]}},
                      {8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};

  // Hardware sets the flag; bit 7 is reserved and never sets
  assign set_vec = rx_events & `RXIE_MASK_FLAGS;

  always_comb begin
    st_nxt   = st_r;
    clr_vec  = '0;
    flag_vec = '0;

    // Write address and data are taken independently, one write at a time
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_held = 1'h1;
      st_nxt.aw_addr = s_axi_awaddr;
      st_nxt.awready = 1'h0;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_held  = 1'h1;
      st_nxt.wdata   = s_axi_wdata;
      st_nxt.wstrb   = s_axi_wstrb;
      st_nxt.wready  = 1'h0;
    end

    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      st_nxt.aw_held = 1'h0;
      st_nxt.w_held  = 1'h0;
      st_nxt.bvalid  = 1'h1;
      st_nxt.bresp   = `RXIE_RESP_OKAY;
      unique case (st_r.aw_addr)
        `RXIE_OFS_ENABLE: begin
          // Bit 7 stores but gates nothing downstream
          st_nxt.enable = (st_r.enable & ~byte_mask) | (st_r.wdata & byte_mask);
        end
        `RXIE_OFS_FLAGS: begin
          clr_vec = st_r.wdata & byte_mask;
        end
        `RXIE_OFS_SUMMARY: begin
          // Read-only status, a write has no effect
        end
        default: begin
          st_nxt.bresp = `RXIE_RESP_SLVERR;
        end
      endcase
    end

    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid  = 1'h0;
      st_nxt.awready = 1'h1;
      st_nxt.wready  = 1'h1;
    end

    // A set in the cycle of its write-one clear wins, so no event is lost
    flag_vec     = ((st_r.flags & ~clr_vec) | set_vec) & `RXIE_MASK_FLAGS;
    st_nxt.flags = flag_vec;

    // Reads sample register state as it stood at the address handshake
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.arready = 1'h0;
      st_nxt.rvalid  = 1'h1;
      st_nxt.rresp   = `RXIE_RESP_OKAY;
      unique case (s_axi_araddr)
        `RXIE_OFS_ENABLE:  st_nxt.rdata = st_r.enable;
        `RXIE_OFS_FLAGS:   st_nxt.rdata = st_r.flags;
        `RXIE_OFS_SUMMARY: st_nxt.rdata = {`RXIE_SUM_PAD, summary};
        default: begin
          st_nxt.rdata = `RXIE_RST_RDATA;
          st_nxt.rresp = `RXIE_RESP_SLVERR;
        end
      endcase
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid  = 1'h0;
      st_nxt.arready = 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= RST_ST;
    end else begin
      st_r <= st_nxt;
    end
  end

  rxie_gate u_gate (
    .aclk    (aclk),
    .aresetn (aresetn),
    .flags   (st_r.flags),
    .enable  (st_r.enable),
    .summary (summary)
  );

  assign s_axi_awready       = st_r.awready;
  assign s_axi_wready        = st_r.wready;
  assign s_axi_bresp         = st_r.bresp;
  assign s_axi_bvalid        = st_r.bvalid;
  assign s_axi_arready       = st_r.arready;
  assign s_axi_rdata         = st_r.rdata;
  assign s_axi_rresp         = st_r.rresp;
  assign s_axi_rvalid        = st_r.rvalid;
  assign rx_path_event_flags = st_r.flags;
  assign system_irq_summary  = summary;

endmodule : rxie_top

// file: rxie_top_assertions.sv
// Assertions for the receive-path interrupt enable block
`timescale 1ns/1ps
module rxie_top_chk
  import rxie_pkg::*;
(
  // Clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // Watched ports
  input wire logic          s_axi_awready,
  input wire rxie_events_t  rx_events,
  input wire rxie_events_t  rx_path_event_flags,
  input wire rxie_summary_t system_irq_summary
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire [31:0] fl = rx_path_event_flags;
  wire [31:0] ev = rx_events;
  wire        bs = system_irq_summary.rx_buffer_summary;
  wire        gs = system_irq_summary.rx_general_summary;
  property p_set;
    |ev |=> (fl & $past(ev) & 32'hffff_ff7f) == ($past(ev) & 32'hffff_ff7f);
  endproperty
  a_set: assert property (p_set) else $error("event did not set its flag");
  property p_b7; fl[7] == 1'h0; endproperty
  a_b7: assert property (p_b7) else $error("reserved flag bit set");
  property p_bcause; bs |-> ($past(fl) & 32'hffff_0000) != 0; endproperty
  a_bcause: assert property (p_bcause) else $error("buffer summary without flag");
  property p_bdrop; (fl & 32'hffff_0000) == 0 |=> !bs; endproperty
  a_bdrop: assert property (p_bdrop) else $error("buffer summary stuck high");
  property p_gcause; gs |-> ($past(fl) & 32'h0000_ff7f) != 0; endproperty
  a_gcause: assert property (p_gcause) else $error("general summary without flag");
  property p_gdrop; (fl & 32'h0000_ff7f) == 0 |=> !gs; endproperty
  a_gdrop: assert property (p_gdrop) else $error("general summary stuck high");
  // Flags may only fall through a register write, which first drops awready
  property p_hold; s_axi_awready |=> (fl & $past(fl)) == $past(fl); endproperty
  a_hold: assert property (p_hold) else $error("flag lost without clear");
  property p_quiet; fl == 0 && ev == 0 |=> fl == 0; endproperty
  a_quiet: assert property (p_quiet) else $error("flag set without event");
endmodule : rxie_top_chk

bind rxie_top rxie_top_chk chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .rx_events(rx_events), .rx_path_event_flags(rx_path_event_flags),
  .system_irq_summary(system_irq_summary));

// file: tb_top.sv
// Self-checking bench for the receive-path interrupt enable block
`timescale 1ns/1ps
`include "rxie_regs.svh"
module tb_top
  import rxie_pkg::*;
;
  typedef struct packed {logic [31:0] en; logic [31:0] ev; logic [1:0] sum;} rxie_row_t;
  logic          aclk = 1'h0, aresetn = 1'h0;
  logic [31:0]   s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, rd_d, s_axi_rdata;
  logic [3:0]    s_axi_wstrb = 4'hf;
  logic          s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  // Answers are always accepted at once, so the bench never stalls the slave
  logic          s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp, resp;
  rxie_events_t  rx_events = '0, rx_path_event_flags;
  rxie_summary_t system_irq_summary;
  wire [1:0]     sm = system_irq_summary;
  rxie_row_t     rows[$];
  int            num_errors = 0, cmp_count = 0, cycles = 0;

  always #5 aclk = ~aclk;

  rxie_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rx_events, .rx_path_event_flags, .system_irq_summary);

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // A hang turns into a counted mismatch instead of a silent stop
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd

  task automatic run_row(input rxie_row_t w);
    wr(`RXIE_OFS_ENABLE, w.en);
    rx_events <= w.ev;
    @(posedge aclk);
    rx_events <= '0;
    repeat (2) @(posedge aclk);
    chk("buf", sm[1], w.sum[1]);
    chk("gen", sm[0], w.sum[0]);
    chk("flags", rx_path_event_flags, w.ev & `RXIE_MASK_FLAGS);
    rd(`RXIE_OFS_FLAGS);
    chk("flag reg", rd_d, w.ev & `RXIE_MASK_FLAGS);
    rd(`RXIE_OFS_SUMMARY);
    chk("sum reg", rd_d, {30'h0, w.sum});
    wr(`RXIE_OFS_FLAGS, 32'hffff_ffff);
  endtask : run_row

  initial begin
    for (int i = 0; i < 32; i++)
      rows.push_back('{32'h1 << i, 32'h1 << i, i > 15 ? 2'h2 : (i == 7 ? 2'h0 : 2'h1)});
    // Enables on the opposite group must leave both summaries low; with every bit enabled both go high
    rows.push_back('{32'h0000_ffff, 32'hffff_0000, 2'h0});
    rows.push_back('{32'hffff_0000, 32'h0000_ff7f, 2'h0});
    rows.push_back('{32'hffff_ffff, 32'hffff_ffff, 2'h3});
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    wr(`RXIE_OFS_ENABLE, 32'hffff_ffff);
    chk("ok bresp", resp, `RXIE_RESP_OKAY);
    rd(`RXIE_OFS_ENABLE);
    chk("enable", rd_d, 32'hffff_ffff);
    chk("ok rresp", resp, `RXIE_RESP_OKAY);
    foreach (rows[i]) run_row(rows[i]);
    rd(32'h0000_0400);
    chk("bad rresp", resp, `RXIE_RESP_SLVERR);
    chk("bad rdata", rd_d, 32'h0000_0000);
    wr(32'h0000_0400, 32'hffff_ffff);
    chk("bad bresp", resp, `RXIE_RESP_SLVERR);
    // Summary status ignores writes but still answers OKAY
    wr(`RXIE_OFS_SUMMARY, 32'hffff_ffff);
    chk("sum bresp", resp, `RXIE_RESP_OKAY);
    // Only the lowest byte lane may change
    s_axi_wstrb <= 4'h1;
    wr(`RXIE_OFS_ENABLE, 32'h0000_0000);
    s_axi_wstrb <= 4'hf;
    rd(`RXIE_OFS_ENABLE);
    chk("lane enable", rd_d, 32'hffff_ff00);
    // Event lands in the very cycle that the write-one clear completes
    fork
      wr(`RXIE_OFS_FLAGS, 32'hffff_ffff);
      begin
        @(posedge aclk);
        rx_events <= 32'h0100_0001;
        @(posedge aclk);
        rx_events <= '0;
      end
    join
    chk("set wins", rx_path_event_flags, 32'h0100_0001);
    aresetn <= 1'h0;
    repeat (10) @(posedge aclk);
    chk("rst flags", rx_path_event_flags, `RXIE_RST_FLAGS);
    chk("rst sum", sm, 32'h0000_0000);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(`RXIE_OFS_ENABLE);
    chk("rst enable", rd_d, `RXIE_RST_ENABLE);
    give_verdict();
  end
endmodule : tb_top
